/* File: design/tdm_switch_pkg.sv */
package tdm_switch_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the word-wide bus)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_ACCESS_DATA    = 5'h00;
  localparam logic [4:0] OFS_ACCESS_ADDRESS = 5'h04;
  localparam logic [4:0] OFS_ACCESS_COMMAND = 5'h08;
  localparam logic [4:0] OFS_STATUS         = 5'h0C;
  localparam logic [4:0] OFS_PLACEMENT      = 5'h10;

  localparam logic [7:0] RST_PLACEMENT      = 8'h00;
  localparam logic [7:0] RST_ACCESS         = 8'h00;
  localparam logic [3:0] RST_TRISTATE       = 4'h0;
  localparam int         POS_BUSY           = 0;

  // ----------------------------------------------------------------
  // Memory access commands and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_HI_WRITE_CODE  = 4'h7;
  localparam logic [7:0] CMD_CANCEL         = 8'h70;
  localparam logic [7:0] CMD_WRITE_POINTER  = 8'h48;
  localparam logic [7:0] CMD_WRITE_TRISTATE = 8'h60;
  localparam logic [7:0] CMD_READ_POINTER   = 8'hC8;
  localparam logic [7:0] CMD_READ_CODE      = 8'hF0;
  localparam logic [3:0] CODE_UNASSIGNED    = 4'h0;
  localparam logic [3:0] CODE_FULL_SLOT     = 4'h1;

  // ----------------------------------------------------------------
  // Timeslot stream carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [6:0] slot;
    logic [7:0] data;
  } slot_byte_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] slot;
    logic [7:0] data;
    logic [7:0] drive_en;
  } pcm_tx_t;

endpackage

/* File: design/tdm_timeslot_subchannel_switch.sv */
`timescale 1ns/1ps

module tdm_timeslot_subchannel_switch
  import tdm_switch_pkg::*;
#(
  parameter int SLOTS = 128
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  input  wire slot_byte_t  i_line_rx,
  input  wire logic        i_line_tx_req,
  input  wire logic [6:0]  i_line_tx_slot,
  output slot_byte_t       o_line_tx,
  input  wire slot_byte_t  i_pcm_rx,
  input  wire logic        i_pcm_tx_req,
  input  wire logic [6:0]  i_pcm_tx_slot,
  output pcm_tx_t          o_pcm_tx
);

  // ----------------------------------------------------------------
  // Code helpers
  // ----------------------------------------------------------------

  // Bits carried by a code: 8, 4, 2 or 0 when not a switched channel.
  // Codes with the top bit set carry nothing here, so they never switch.
  function automatic logic [3:0] code_width(input logic [3:0] code);
    logic [3:0] w;
    w = 4'h0;
    if (code == CODE_FULL_SLOT) begin
      w = 4'h8;
    end else if (code[3:1] == 3'b001) begin
      w = 4'h4;
    end else if (code[3:2] == 2'b01) begin
      w = 4'h2;
    end
    return w;
  endfunction

  // Lowest PCM bit of the subslot selected by the code.
  // Four-bit codes pick the upper or lower nibble, two-bit codes a bit pair.
  function automatic logic [2:0] pcm_lsb(input logic [3:0] code);
    logic [2:0] p;
    p = 3'h0;
    if (code[3:1] == 3'b001) begin
      p = code[0] ? 3'h4 : 3'h0;
    end else if (code[3:2] == 2'b01) begin
      p = {code[1:0], 1'b0};
    end
    return p;
  endfunction

  // Lowest line-side bit, fixed per port by the two placement bits.
  // The code only says four or two bits; where they sit is the port's choice.
  function automatic logic [2:0] line_lsb(input logic [3:0] code, input logic [1:0] place);
    logic [2:0] p;
    p = 3'h0;
    if (code[3:1] == 3'b001) begin
      p = place[0] ? 3'h0 : 3'h4;
    end else if (code[3:2] == 2'b01) begin
      p = 3'h6 - {place, 1'b0};
    end
    return p;
  endfunction

  // Placement bits of the port owning a line slot; the port is the top two
  // slot bits, so there are four ports of 32 slots each.
  function automatic logic [1:0] port_place(input logic [7:0] pl, input logic [6:0] slot);
    logic [1:0] p;
    p = pl[{slot[6:5], 1'b0} +: 2];
    return p;
  endfunction

  // Mask of the low bits that a code of the given width carries.
  function automatic logic [7:0] width_mask(input logic [3:0] w);
    logic [7:0] m;
    m = 8'h00;
    case (w)
      4'h8:    m = 8'hFF;
      4'h4:    m = 8'h0F;
      4'h2:    m = 8'h03;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Pointer and code per line slot, driver enables per PCM slot, and one
  // data memory per direction. Pointers and data memories are not reset,
  // which is harmless because every code resets to unassigned and every driver enable to off.
  logic [7:0] cm_data  [SLOTS];
  logic [3:0] cm_code  [SLOTS];
  logic [3:0] tristate [SLOTS];
  logic [7:0] dm_up    [SLOTS];
  logic [7:0] dm_down  [SLOTS];

  // Host-visible access registers and bus bookkeeping.
  logic [7:0] access_data;
  logic [7:0] access_address;
  logic [7:0] access_command;
  logic [7:0] placement;
  logic       busy;
  logic       read_code_pending;
  logic       bus_ack;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // A request is taken on the edge where waitrequest is already low.
  // Byte lane 0 gates every write, as all registers sit in the low byte.
  wire        bus_req     = i_read | i_write;
  wire        wr_take     = i_write & bus_ack & i_byteenable[0];
  // Offsets decode on the full address, so no alias ever answers.
  wire        hit_data    = (i_address == OFS_ACCESS_DATA);
  wire        hit_addr    = (i_address == OFS_ACCESS_ADDRESS);
  wire        hit_cmd     = (i_address == OFS_ACCESS_COMMAND);
  wire        hit_place   = (i_address == OFS_PLACEMENT);
  wire        hit_status  = (i_address == OFS_STATUS);
  wire [7:0]  wbyte       = i_writedata[7:0];
  wire        cmd_strobe  = wr_take & hit_cmd;
  wire [6:0]  acc_index   = access_address[6:0];

  // Command classes. Any 7Xh writes a code and, except for the cancel code,
  // the pointer too; 48h moves only the pointer of an already coded line.
  wire        cmd_code_wr = cmd_strobe & (wbyte[7:4] == CMD_HI_WRITE_CODE);
  wire        cmd_ptr_wr  = cmd_code_wr & (wbyte != CMD_CANCEL);
  wire        cmd_ptr_only = cmd_strobe & (wbyte == CMD_WRITE_POINTER);
  wire        cmd_tri_wr  = cmd_strobe & (wbyte == CMD_WRITE_TRISTATE);
  wire        cmd_rd_ptr  = cmd_strobe & (wbyte == CMD_READ_POINTER);
  wire        cmd_rd_code = cmd_strobe & (wbyte == CMD_READ_CODE);

  // Status holds only the busy flag; its other bits read as zero.
  wire [7:0]  status_word = 8'(busy) << POS_BUSY;

  // Read selection; unmapped offsets answer zero so a probe does no harm.
  wire [7:0]  read_mux =
      hit_data   ? access_data :
      hit_addr   ? access_address :
      hit_cmd    ? access_command :
      hit_status ? status_word :
      hit_place  ? placement : 8'h00;

  // ----------------------------------------------------------------
  // Avalon-MM answer: waitrequest drops one cycle after a request.
  // ----------------------------------------------------------------

  // Registered answer keeps both outputs straight from flip-flops; the cost
  // is one wait cycle on every access.
  // bus_ack blocks a second answer while the master still holds the request
  // on the edge that completes it, so each access takes exactly two cycles.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_ack       <= 1'b0;
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0000_0000;
    end else begin
      bus_ack       <= bus_req & ~bus_ack;
      o_waitrequest <= ~(bus_req & ~bus_ack);
      o_readdata    <= {24'h00_0000, read_mux};
    end
  end

  // ----------------------------------------------------------------
  // Host-visible registers
  // ----------------------------------------------------------------

  // A memory read result overrides a host write to the data register.
  // Such a write is lost; a host that polls busy first never meets the case.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      access_data <= RST_ACCESS;
    end else if (busy) begin
      access_data <= read_code_pending ?
          {4'h0, cm_code[acc_index]} : cm_data[acc_index];
    end else if (wr_take & hit_data) begin
      access_data <= wbyte;
    end
  end

  // Plain host registers; the command register keeps the last command so that
  // software can read back what it issued, unknown codes included.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      access_address <= RST_ACCESS;
      access_command <= RST_ACCESS;
      placement      <= RST_PLACEMENT;
    end else begin
      if (wr_take & hit_addr) begin
        access_address <= wbyte;
      end
      if (cmd_strobe) begin
        access_command <= wbyte;
      end
      if (wr_take & hit_place) begin
        placement <= wbyte;
      end
    end
  end

  // Busy rises with a read command and falls when the data register is loaded.
  // The result lands one edge after the command, so with two cycles per bus
  // access the first status poll already reads zero.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy              <= 1'b0;
      read_code_pending <= 1'b0;
    end else begin
      busy              <= cmd_rd_ptr | cmd_rd_code;
      read_code_pending <= cmd_rd_code;
    end
  end

  // ----------------------------------------------------------------
  // Control memory and tristate field writes
  // ----------------------------------------------------------------

  // Codes reset to unassigned so no slot switches before it is programmed.
  // Drivers reset to high impedance, so nothing reaches the highway early.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        cm_code[i]  <= CODE_UNASSIGNED;
        tristate[i] <= RST_TRISTATE;
      end
    end else begin
      if (cmd_code_wr) begin
        cm_code[acc_index] <= wbyte[3:0];
      end
      // The nibble comes from the data register loaded before the command.
      if (cmd_tri_wr) begin
        tristate[acc_index] <= access_data[3:0];
      end
    end
  end

  // Pointer field; the cancel command leaves it untouched.
  // A cancelled line thus keeps its pointer, which a read-back still shows.
  always_ff @(posedge i_ref_clk) begin
    if (cmd_ptr_wr | cmd_ptr_only) begin
      cm_data[acc_index] <= access_data;
    end
  end

  // ----------------------------------------------------------------
  // Upstream: line receive slot into the pointed PCM slot
  // ----------------------------------------------------------------
  // Look up the received line slot: code, pointer and port placement give
  // which line bits move and where they land in the pointed PCM byte.
  wire [3:0]  up_code  = cm_code[i_line_rx.slot];
  wire [6:0]  up_ptr   = cm_data[i_line_rx.slot][6:0];
  wire [1:0]  up_place = port_place(placement, i_line_rx.slot);
  wire [3:0]  up_width = code_width(up_code);
  wire [7:0]  up_mask  = width_mask(up_width);
  wire [2:0]  up_plsb  = pcm_lsb(up_code);
  wire [7:0]  up_bits  = (i_line_rx.data >> line_lsb(up_code, up_place)) & up_mask;
  wire [7:0]  up_pmask = up_mask << up_plsb;
  wire        up_go    = i_line_rx.valid & ~up_code[3] & (up_width != 4'h0);

  // Only the selected PCM bits change, so subslots from other line slots
  // sharing this PCM slot survive.
  // The PCM receive side stores whole bytes; slots are picked apart on the way out.
  always_ff @(posedge i_ref_clk) begin
    if (up_go) begin
      dm_up[up_ptr] <= (dm_up[up_ptr] & ~up_pmask) | (up_bits << up_plsb);
    end
    if (i_pcm_rx.valid) begin
      dm_down[i_pcm_rx.slot] <= i_pcm_rx.data;
    end
  end

  // ----------------------------------------------------------------
  // Downstream: pointed PCM slot onto the line transmit slot
  // ----------------------------------------------------------------
  // Look up the requested line slot the same way, reading the PCM byte
  // that its pointer names.
  wire [3:0]  dn_code  = cm_code[i_line_tx_slot];
  wire [6:0]  dn_ptr   = cm_data[i_line_tx_slot][6:0];
  wire [1:0]  dn_place = port_place(placement, i_line_tx_slot);
  wire [3:0]  dn_width = code_width(dn_code);
  wire [7:0]  dn_mask  = width_mask(dn_width);
  wire [2:0]  dn_llsb  = line_lsb(dn_code, dn_place);
  wire [7:0]  dn_bits  = (dm_down[dn_ptr] >> pcm_lsb(dn_code)) & dn_mask;
  wire        dn_go    = ~dn_code[3] & (dn_width != 4'h0);
  // Bits outside the subslot idle high, as on an undriven line.
  // The pointer is read even for an unswitched slot; dn_go discards it.
  wire [7:0]  dn_data  = dn_go ?
      ((8'hFF & ~(dn_mask << dn_llsb)) | (dn_bits << dn_llsb)) : 8'hFF;

  // ----------------------------------------------------------------
  // PCM transmit with per-pair driver enables
  // ----------------------------------------------------------------
  // Each nibble bit fans out to one bit pair of the PCM transmit byte.
  wire [3:0]  tx_tri   = tristate[i_pcm_tx_slot];
  wire [7:0]  tx_en    = {{2{tx_tri[3]}}, {2{tx_tri[2]}},
                          {2{tx_tri[1]}}, {2{tx_tri[0]}}};

  // Outputs update one clock after each slot request.
  // Each answer stands one cycle; the echoed slot lets the far side pair it
  // with its request without counting cycles.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_line_tx <= '0;
      o_pcm_tx  <= '0;
    end else begin
      o_line_tx.valid   <= i_line_tx_req;
      o_line_tx.slot    <= i_line_tx_slot;
      o_line_tx.data    <= dn_data;
      o_pcm_tx.valid    <= i_pcm_tx_req;
      o_pcm_tx.slot     <= i_pcm_tx_slot;
      o_pcm_tx.data     <= dm_up[i_pcm_tx_slot];
      o_pcm_tx.drive_en <= tx_en;
    end
  end

endmodule

/* File: tb/tdm_switch_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks of the switch
// ----------------------------------------------------------------
module tdm_switch_properties
  import tdm_switch_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic [4:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0]  i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        i_line_tx_req,
  input wire logic [6:0]  i_line_tx_slot,
  input wire slot_byte_t  o_line_tx,
  input wire logic        i_pcm_tx_req,
  input wire logic [6:0]  i_pcm_tx_slot,
  input wire pcm_tx_t     o_pcm_tx
);
  logic [7:0] place;
  wire        ack = !o_waitrequest;
  wire        req = i_read || i_write;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // Shadow of the placement register, so every read ties back to the last write.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      place <= RST_PLACEMENT;
    end else if (ack && i_write && i_address == OFS_PLACEMENT && i_byteenable[0]) begin
      place <= i_writedata[7:0];
    end
  end

  AST_ONE_WAIT: assert property (req && o_waitrequest |=> ack)
    else $error("request not answered on the next edge");
  AST_ACK_PULSE: assert property (ack |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_NO_IDLE_ACK: assert property (!req |=> o_waitrequest)
    else $error("answer without a request");
  AST_CODE_LOW: assert property (ack && i_read |-> o_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  AST_UNMAPPED: assert property (ack && i_read && i_address > OFS_PLACEMENT |-> o_readdata == 0)
    else $error("unmapped read not zero");
  AST_PLACE: assert property (ack && i_read && i_address == OFS_PLACEMENT
    |-> o_readdata[7:0] == place)
    else $error("placement read differs from last write");
  AST_PCM_SLOT: assert property (i_pcm_tx_req
    |=> o_pcm_tx.valid && o_pcm_tx.slot == $past(i_pcm_tx_slot))
    else $error("transmit slot not answered one cycle later");
  AST_PCM_QUIET: assert property (!i_pcm_tx_req |=> !o_pcm_tx.valid)
    else $error("transmit valid without request");
  AST_PAIRS: assert property (o_pcm_tx.valid
    |-> (o_pcm_tx.drive_en & 8'h55) == ((o_pcm_tx.drive_en >> 1) & 8'h55))
    else $error("driver enable split inside a bit pair");
  AST_LINE_SLOT: assert property (i_line_tx_req
    |=> o_line_tx.valid && o_line_tx.slot == $past(i_line_tx_slot))
    else $error("line transmit slot not answered one cycle later");
  AST_LINE_QUIET: assert property (!i_line_tx_req |=> !o_line_tx.valid)
    else $error("line transmit valid without request");
endmodule

bind tdm_timeslot_subchannel_switch tdm_switch_properties chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_line_tx_req(i_line_tx_req),
  .i_line_tx_slot(i_line_tx_slot), .o_line_tx(o_line_tx), .i_pcm_tx_req(i_pcm_tx_req),
  .i_pcm_tx_slot(i_pcm_tx_slot), .o_pcm_tx(o_pcm_tx)
);

/* File: tb/tdm_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor: bus master and memory command sequences
// ----------------------------------------------------------------
module tdm_host_model
  import tdm_switch_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest,
  output logic      [4:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata,
  output logic      [3:0]  o_byteenable
);
  initial begin
    o_address    = 5'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h00000000;
    o_byteenable = 4'hF;
  end

  // One access; the request stands until waitrequest is seen low, then the
  // released lines are inverted so stale values cannot pass for good ones.
  task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge i_ref_clk);
    o_address   <= a;
    o_writedata <= {24'h000000, d};
    o_read      <= rd;
    o_write     <= !rd;
    do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
    q = i_readdata[7:0];
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    o_address   <= ~a;
    o_writedata <= ~o_writedata;
  endtask

  // Data, address, then command, in that order.
  task automatic mem_cmd(input logic [7:0] d, a, c);
    logic [7:0] q;
    access(1'b0, OFS_ACCESS_DATA, d, q);
    access(1'b0, OFS_ACCESS_ADDRESS, a, q);
    access(1'b0, OFS_ACCESS_COMMAND, c, q);
  endtask

  // A read command is followed by polling busy to zero before the data read.
  task automatic mem_rd(input logic [7:0] a, c, output logic [7:0] q);
    logic [7:0] s;
    access(1'b0, OFS_ACCESS_ADDRESS, a, q);
    access(1'b0, OFS_ACCESS_COMMAND, c, q);
    do access(1'b1, OFS_STATUS, 8'h00, s); while (s[POS_BUSY] !== 1'b0);
    access(1'b1, OFS_ACCESS_DATA, 8'h00, q);
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb import tdm_switch_pkg::*;;
  logic        clk, rst_b, rd, wr, waitreq, ltx_req, ptx_req;
  logic [4:0]  address;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [6:0]  ltx_slot, ptx_slot;
  slot_byte_t  line_rx, pcm_rx, line_tx;
  pcm_tx_t     pcm_tx;
  int          err_count, num_checks, m, pl, ll;
  logic [7:0]  q, en, ld, pd, exp_up [2];
  logic [7:0]  ts_data [3] = '{8'hAF, 8'h35, 8'hC0};
  logic [7:0]  ts_en [3]   = '{8'hFF, 8'h33, 8'h00};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  tdm_timeslot_subchannel_switch dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_address(address), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_line_rx(line_rx), .i_line_tx_req(ltx_req), .i_line_tx_slot(ltx_slot),
    .o_line_tx(line_tx), .i_pcm_rx(pcm_rx), .i_pcm_tx_req(ptx_req),
    .i_pcm_tx_slot(ptx_slot), .o_pcm_tx(pcm_tx));

  tdm_host_model host (.i_ref_clk(clk), .i_readdata(rdata), .i_waitrequest(waitreq),
    .o_address(address), .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Mask, PCM low bit and line low bit of a code at a port placement.
  function automatic void place(input logic [3:0] c, input logic [1:0] p,
                                output int m, output int pl, output int ll);
    m  = c[2] ? 3 : 15;
    pl = c[2] ? 2 * c[1:0] : 4 * c[0];
    ll = c[2] ? 6 - 2 * p : (p[0] ? 0 : 4);
  endfunction

  // One received slot pulse; the released fields are inverted.
  task automatic feed_rx(input logic to_pcm, input logic [6:0] s, input logic [7:0] d);
    @(posedge clk);
    if (to_pcm) begin
      pcm_rx <= '{1'b1, s, d};
    end else begin
      line_rx <= '{1'b1, s, d};
    end
    @(posedge clk);
    pcm_rx  <= '{1'b0, ~s, ~d};
    line_rx <= '{1'b0, ~s, ~d};
  endtask

  task automatic take_tx(input logic pcm, input logic [6:0] s, output logic [7:0] d,
                         output logic [7:0] e);
    @(posedge clk);
    ptx_req  <= pcm;
    ltx_req  <= !pcm;
    ptx_slot <= s;
    ltx_slot <= s;
    @(posedge clk);
    ptx_req  <= 1'b0;
    ltx_req  <= 1'b0;
    @(posedge clk);
    d = pcm ? pcm_tx.data : line_tx.data;
    e = pcm_tx.drive_en;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    line_rx = '0;
    pcm_rx = '0;
    {ltx_req, ptx_req, ltx_slot, ptx_slot} = '0;
    exp_up = '{8'h00, 8'h00};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    host.access(1'b1, OFS_PLACEMENT, 8'h00, q);
    chk("placement reset", RST_PLACEMENT, q);
    host.access(1'b1, 5'h14, 8'h00, q);
    chk("unmapped", 8'h00, q);
    host.mem_cmd(8'd20, 8'd31, 8'h71);
    host.mem_rd(8'd31, CMD_READ_POINTER, q);
    chk("pointer", 8'd20, q);
    host.mem_rd(8'd31, CMD_READ_CODE, q);
    chk("code", 8'h01, q);
    feed_rx(1'b0, 7'd31, 8'hA5);
    take_tx(1'b1, 7'd20, q, en);
    chk("pcm full", 8'hA5, q);
    feed_rx(1'b1, 7'd20, 8'h3C);
    take_tx(1'b0, 7'd31, q, en);
    chk("line full", 8'h3C, q);
    feed_rx(1'b0, 7'd31, 8'h00);
    host.mem_cmd(8'd21, 8'd31, CMD_WRITE_POINTER);
    host.mem_rd(8'd31, CMD_READ_POINTER, q);
    chk("pointer moved", 8'd21, q);
    host.mem_rd(8'd31, CMD_READ_CODE, q);
    chk("code kept", 8'h01, q);
    feed_rx(1'b0, 7'd31, 8'h00);
    host.mem_cmd(8'hFF, 8'd31, CMD_CANCEL);
    host.mem_rd(8'd31, CMD_READ_CODE, q);
    chk("cancelled", 8'h00, q);
    take_tx(1'b0, 7'd31, q, en);
    chk("line idle", 8'hFF, q);
    for (int i = 0; i < 3; i++) begin
      host.mem_cmd(ts_data[i], 8'd20, CMD_WRITE_TRISTATE);
      take_tx(1'b1, 7'd20, q, en);
      chk("drive enable", ts_en[i], en);
    end
    // Ports 3..0 take placements 11, 10, 01, 00; every sub-slot code is used.
    host.access(1'b0, OFS_PLACEMENT, 8'hE4, q);
    host.access(1'b1, OFS_PLACEMENT, 8'h00, q);
    chk("placement", 8'hE4, q);
    // A write without byte lane 0 must leave the placement as it was.
    host.o_byteenable <= 4'hE;
    host.access(1'b0, OFS_PLACEMENT, 8'h1B, q);
    host.o_byteenable <= 4'hF;
    host.access(1'b1, OFS_PLACEMENT, 8'h00, q);
    chk("placement lane", 8'hE4, q);
    for (int k = 0; k < 6; k++) begin
      host.mem_cmd(8'(20 + k / 4), 8'((k % 4) * 32 + k), 8'(8'h77 - k));
    end
    for (int k = 0; k < 6; k++) begin
      ld = 8'(8'hA5 + k * 31);
      place(4'(7 - k), 2'(k % 4), m, pl, ll);
      feed_rx(1'b0, 7'((k % 4) * 32 + k), ld);
      exp_up[k / 4] = (exp_up[k / 4] & ~8'(m << pl)) | 8'(((ld >> ll) & m) << pl);
    end
    // A code with the top bit set is stored but never switches.
    host.mem_cmd(8'd21, 8'd31, 8'h7B);
    host.mem_rd(8'd31, CMD_READ_CODE, q);
    chk("code parked", 8'h0B, q);
    feed_rx(1'b0, 7'd31, 8'h00);
    take_tx(1'b0, 7'd31, q, en);
    chk("line parked", 8'hFF, q);
    take_tx(1'b1, 7'd20, q, en);
    chk("pcm pairs", exp_up[0], q);
    take_tx(1'b1, 7'd21, q, en);
    chk("pcm nibbles", exp_up[1], q);
    feed_rx(1'b1, 7'd20, 8'hC6);
    feed_rx(1'b1, 7'd21, 8'h5A);
    for (int k = 0; k < 6; k++) begin
      pd = (k < 4) ? 8'hC6 : 8'h5A;
      place(4'(7 - k), 2'(k % 4), m, pl, ll);
      take_tx(1'b0, 7'((k % 4) * 32 + k), q, en);
      chk("line sub", ~8'(m << ll) | 8'(((pd >> pl) & m) << ll), q);
    end
    print_verdict();
  end
endmodule
